// [include/hpb_pkg.sv]
// Shared constants, state codes and helpers for both ends of the host parallel port.
// Assumes one 250 MHz clock on each end and pin-level meeting in host_bus_if.
package hpb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int DATA_W    = 32;
  localparam int HALF_W    = 16;
  localparam int ADDR_LSB  = 2;
  localparam int ADDR_MSB  = 15;
  localparam int ADDR_W    = ADDR_MSB - ADDR_LSB + 1;
  localparam int UPPER_LSB = 5;
  localparam int N_EVENTS  = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PHASE_NS      = 40;
  localparam int ACCESS_NS     = 80;
  localparam int PHASE_CYC     = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Pin levels
  localparam logic MUX_MODE   = 1'h1;
  localparam logic SIZE_32BIT = 1'h1;
  localparam logic PIN_IDLE   = 1'h1;

  //////////////////////////////////////////////////////////////////////////////
  // States
  typedef enum logic [2:0] {
    DEV_IDLE  = 3'h1,
    DEV_READ  = 3'h2,
    DEV_WRITE = 3'h4
  } dev_state_t;

  typedef enum logic [4:0] {
    HST_IDLE    = 5'h01,
    HST_ADDR    = 5'h02,
    HST_HOLD    = 5'h04,
    HST_ACCESS  = 5'h08,
    HST_RECOVER = 5'h10
  } host_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Upper data half is dead on a 16-bit bus
  function automatic logic [DATA_W-1:0] size_mask(input logic [DATA_W-1:0] d,
                                                  input logic              wide);
    size_mask = wide ? d : {{(DATA_W-HALF_W){1'b0}}, d[HALF_W-1:0]};
  endfunction

endpackage

// [include/host_bus_if.sv]
// Pin-level meeting point of host end and device end.
// Resolves the shared data lines from both drivers' enables.
`timescale 1ns/10ps
interface host_bus_if;
  logic                                          cs_n;
  logic                                          oe_n;
  logic                                          we_n;
  logic                                          addr_bit2_or_latch_strobe;
  logic                                          addr_bit3_pin;
  logic                                          addr_bit4_pin;
  logic [hpb_pkg::ADDR_MSB:hpb_pkg::UPPER_LSB]   addr_upper;
  logic                                          bus_mux_select;
  logic                                          size_32;
  logic [hpb_pkg::DATA_W-1:0]                    host_d_out;
  logic                                          host_d_oe;
  logic [hpb_pkg::DATA_W-1:0]                    dev_d_out;
  logic                                          dev_d_oe;
  logic [hpb_pkg::DATA_W-1:0]                    data_lines;
  logic                                          host_irq_zero;
  logic                                          host_irq_one;
  logic                                          host_irq_two;

  // Undriven lines read as zero; contention gives the host priority
  assign data_lines = host_d_oe ? host_d_out : (dev_d_oe ? dev_d_out : '0);

  modport device (
    input  cs_n, oe_n, we_n, addr_bit2_or_latch_strobe, addr_bit3_pin, addr_bit4_pin,
    input  addr_upper, bus_mux_select, size_32, data_lines,
    output dev_d_out, dev_d_oe, host_irq_zero, host_irq_one, host_irq_two
  );

  modport host (
    output cs_n, oe_n, we_n, addr_bit2_or_latch_strobe, addr_bit3_pin, addr_bit4_pin,
    output addr_upper, bus_mux_select, size_32, host_d_out, host_d_oe,
    input  data_lines, host_irq_zero, host_irq_one, host_irq_two
  );
endinterface

// [rtl/hpb_device_end.sv]
// Device end of the host parallel port: pin sampling, cycle decode, interrupt lines.
// Assumes all bus pins are asynchronous to clock_i and are held by the host
// for several cycles per phase; the user side answers reads in the same cycle as rd_req_o.
// Straps must stay steady from before reset until well after its release.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module hpb_device_end #(
  parameter int N_EVENTS = hpb_pkg::N_EVENTS
) (
  // Clock and reset
  input  wire logic                                  clock_i,
  input  wire logic                                  rst_i,
  // Pins
  host_bus_if.device                                 bus,
  // Access requests to the switch core
  output logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB] acc_addr_o,
  output logic                                       rd_req_o,
  input  wire logic [hpb_pkg::DATA_W-1:0]            rd_data_i,
  output logic                                       wr_req_o,
  output logic [hpb_pkg::DATA_W-1:0]                 wr_data_o,
  // Configuration seen by the core
  output logic                                       size32_o,
  output logic                                       mux_mode_o,
  // Interrupt events and per-line selection
  input  wire logic [N_EVENTS-1:0]                   events_i,
  input  wire logic [N_EVENTS-1:0]                   irq_sel_zero_i,
  input  wire logic [N_EVENTS-1:0]                   irq_sel_one_i,
  input  wire logic [N_EVENTS-1:0]                   irq_sel_two_i
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    hpb_pkg::dev_state_t                          state;
    // Pin synchronisers, two stages each
    logic [1:0]                                   cs_s;
    logic [1:0]                                   oe_s;
    logic [1:0]                                   we_s;
    logic [1:0]                                   mbs_s;
    logic [1:0]                                   size_s;
    logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB]   a_s1;
    logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB]   a_s2;
    logic [hpb_pkg::DATA_W-1:0]                   d_s1;
    logic [hpb_pkg::DATA_W-1:0]                   d_s2;
    // Cycle tracking
    logic                                         cs_prev;
    logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB]   mux_addr;
    logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB]   addr;
    logic                                         in_reset;
    logic                                         size32;
    logic                                         rd_req;
    logic                                         rd_ready;
    logic [hpb_pkg::DATA_W-1:0]                   rd_data;
    logic                                         d_oe;
    logic                                         wr_req;
    logic [hpb_pkg::DATA_W-1:0]                   wr_data;
    logic [2:0]                                   irq;
  } dev_reg_t;

  dev_reg_t st_ff;
  dev_reg_t nxt_st;

  logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB] addr_pins;
  logic                                       mux;
  logic                                       cs_fall;
  logic                                       cs_rise;
  logic                                       strobe;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt decode
  // Levels in, levels out: a source must hold its event until the host reacts
  function automatic logic irq_hit(input logic [N_EVENTS-1:0] ev,
                                   input logic [N_EVENTS-1:0] sel);
    irq_hit = |(ev & sel);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin gathering
  // Bit two doubles as the latch strobe; it rides the same synchroniser
  assign addr_pins = {bus.addr_upper, bus.addr_bit4_pin, bus.addr_bit3_pin,
                      bus.addr_bit2_or_latch_strobe};
  assign mux       = st_ff.mbs_s[1] == hpb_pkg::MUX_MODE;
  assign strobe    = st_ff.a_s2[hpb_pkg::ADDR_LSB];
  // Edges judged from the second stage on, never the first
  assign cs_fall   = st_ff.cs_prev & ~st_ff.cs_s[1];
  assign cs_rise   = ~st_ff.cs_prev & st_ff.cs_s[1];

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.cs_s     = {st_ff.cs_s[0], bus.cs_n};
    nxt_st.oe_s     = {st_ff.oe_s[0], bus.oe_n};
    nxt_st.we_s     = {st_ff.we_s[0], bus.we_n};
    nxt_st.mbs_s    = {st_ff.mbs_s[0], bus.bus_mux_select};
    nxt_st.size_s   = {st_ff.size_s[0], bus.size_32};
    nxt_st.a_s1     = addr_pins;
    nxt_st.a_s2     = st_ff.a_s1;
    nxt_st.d_s1     = bus.data_lines;
    nxt_st.d_s2     = st_ff.d_s1;
    nxt_st.cs_prev  = st_ff.cs_s[1];
    nxt_st.in_reset = 1'b0;
    nxt_st.rd_req   = 1'b0;
    nxt_st.wr_req   = 1'b0;

    // Strap is taken once, on the first cycle out of reset
    if (st_ff.in_reset) begin
      nxt_st.size32 = st_ff.size_s[1] == hpb_pkg::SIZE_32BIT;
    end

    // Shared lines tracked while the strobe is high, frozen when it drops
    if (mux && strobe && (st_ff.state == hpb_pkg::DEV_IDLE)) begin
      nxt_st.mux_addr = st_ff.d_s2[hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB];
    end

    unique case (st_ff.state)
      hpb_pkg::DEV_IDLE: begin
        nxt_st.d_oe     = 1'b0;
        nxt_st.rd_ready = 1'b0;
        if (cs_fall) begin
          // Dedicated pins are not looked at in mux mode
          nxt_st.addr = mux ? st_ff.mux_addr : st_ff.a_s2;
          if (st_ff.we_s[1]) begin
            nxt_st.state  = hpb_pkg::DEV_READ;
            nxt_st.rd_req = 1'b1;
          end else begin
            nxt_st.state = hpb_pkg::DEV_WRITE;
          end
        end
      end
      hpb_pkg::DEV_READ: begin
        if (st_ff.rd_req) begin
          nxt_st.rd_data  = hpb_pkg::size_mask(rd_data_i, st_ff.size32);
          nxt_st.rd_ready = 1'b1;
        end
        // Release lags the pin by the synchroniser; host must wait before reuse
        nxt_st.d_oe = st_ff.rd_ready & ~st_ff.oe_s[1];
        if (cs_rise) begin
          nxt_st.state    = hpb_pkg::DEV_IDLE;
          nxt_st.d_oe     = 1'b0;
          nxt_st.rd_ready = 1'b0;
        end
      end
      hpb_pkg::DEV_WRITE: begin
        nxt_st.d_oe = 1'b0;
        if (cs_rise) begin
          // Data and chip select share the same sampling lag
          nxt_st.wr_data = hpb_pkg::size_mask(st_ff.d_s2, st_ff.size32);
          nxt_st.wr_req  = 1'b1;
          nxt_st.state   = hpb_pkg::DEV_IDLE;
        end
      end
    endcase

    nxt_st.irq[0] = irq_hit(events_i, irq_sel_zero_i);
    nxt_st.irq[1] = irq_hit(events_i, irq_sel_one_i);
    nxt_st.irq[2] = irq_hit(events_i, irq_sel_two_i);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_ff          <= '0;
      st_ff.state    <= hpb_pkg::DEV_IDLE;
      st_ff.cs_s     <= {2{hpb_pkg::PIN_IDLE}};
      st_ff.oe_s     <= {2{hpb_pkg::PIN_IDLE}};
      st_ff.we_s     <= {2{hpb_pkg::PIN_IDLE}};
      st_ff.cs_prev  <= hpb_pkg::PIN_IDLE;
      st_ff.in_reset <= 1'b1;
      st_ff.size32   <= hpb_pkg::SIZE_32BIT;
      // Straps keep sampling in reset so the first edge out sees a settled value
      st_ff.mbs_s    <= nxt_st.mbs_s;
      st_ff.size_s   <= nxt_st.size_s;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign acc_addr_o        = st_ff.addr;
  assign rd_req_o          = st_ff.rd_req;
  assign wr_req_o          = st_ff.wr_req;
  assign wr_data_o         = st_ff.wr_data;
  assign size32_o          = st_ff.size32;
  assign mux_mode_o        = mux;
  assign bus.dev_d_out     = st_ff.rd_data;
  assign bus.dev_d_oe      = st_ff.d_oe;
  assign bus.host_irq_zero = st_ff.irq[0];
  assign bus.host_irq_one  = st_ff.irq[1];
  assign bus.host_irq_two  = st_ff.irq[2];

endmodule // hpb_device_end

// [rtl/hpb_host_end.sv]
// Host end of the parallel port: turns one command into a timed pin cycle.
// Assumes the device end samples pins through two flip-flops on its own clock.
`timescale 1ns/10ps
module hpb_host_end #(
  parameter int PHASE_CYC  = hpb_pkg::PHASE_CYC,
  parameter int ACCESS_CYC = hpb_pkg::ACCESS_CYC
) (
  // Clock and reset
  input  wire logic                                  clock_i,
  input  wire logic                                  rst_i,
  // Pins
  host_bus_if.host                                   bus,
  // Bus straps
  input  wire logic                                  mux_mode_i,
  input  wire logic                                  size32_i,
  // Commands
  input  wire logic                                  cmd_valid_i,
  output logic                                       cmd_ready_o,
  input  wire logic                                  cmd_write_i,
  input  wire logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB] cmd_addr_i,
  input  wire logic [hpb_pkg::DATA_W-1:0]            cmd_wdata_i,
  // Read answers
  output logic                                       rd_valid_o,
  output logic [hpb_pkg::DATA_W-1:0]                 rd_data_o,
  // Interrupt lines, synchronised
  output logic [2:0]                                 irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    hpb_pkg::host_state_t                         state;
    logic [hpb_pkg::CNT_W-1:0]                    cnt;
    logic                                         mux;
    logic                                         write;
    logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB]   addr;
    logic [hpb_pkg::DATA_W-1:0]                   wdata;
    logic                                         cs_n;
    logic                                         oe_n;
    logic                                         we_n;
    logic                                         ale;
    logic [hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB]   apins;
    logic [hpb_pkg::DATA_W-1:0]                   d_out;
    logic                                         d_oe;
    logic [hpb_pkg::DATA_W-1:0]                   d_s1;
    logic [hpb_pkg::DATA_W-1:0]                   d_s2;
    logic [2:0]                                   irq_s1;
    logic [2:0]                                   irq_s2;
    logic                                         rd_valid;
    logic [hpb_pkg::DATA_W-1:0]                   rd_data;
  } host_reg_t;

  localparam logic [hpb_pkg::CNT_W-1:0] PHASE_LAST  = hpb_pkg::CNT_W'(PHASE_CYC - 1);
  localparam logic [hpb_pkg::CNT_W-1:0] ACCESS_LAST = hpb_pkg::CNT_W'(ACCESS_CYC - 1);

  host_reg_t st_ff;
  host_reg_t nxt_st;
  logic      expired;

  assign expired = st_ff.cnt == '0;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.d_s1     = bus.data_lines;
    nxt_st.d_s2     = st_ff.d_s1;
    nxt_st.irq_s1   = {bus.host_irq_two, bus.host_irq_one, bus.host_irq_zero};
    nxt_st.irq_s2   = st_ff.irq_s1;
    nxt_st.rd_valid = 1'b0;
    if (!expired) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end

    unique case (st_ff.state)
      hpb_pkg::HST_IDLE: begin
        if (cmd_valid_i) begin
          nxt_st.mux   = mux_mode_i == hpb_pkg::MUX_MODE;
          nxt_st.write = cmd_write_i;
          nxt_st.addr  = cmd_addr_i;
          nxt_st.wdata = hpb_pkg::size_mask(cmd_wdata_i, size32_i);
          nxt_st.we_n  = ~cmd_write_i;
          nxt_st.cnt   = PHASE_LAST;
          nxt_st.state = hpb_pkg::HST_ADDR;
          if (mux_mode_i == hpb_pkg::MUX_MODE) begin
            // Address goes out on the shared lines under the strobe
            nxt_st.d_out = '0;
            nxt_st.d_out[hpb_pkg::ADDR_MSB:hpb_pkg::ADDR_LSB] = cmd_addr_i;
            nxt_st.d_oe  = 1'b1;
            nxt_st.ale   = 1'b1;
          end else begin
            nxt_st.apins = cmd_addr_i;
          end
        end
      end
      hpb_pkg::HST_ADDR: begin
        if (expired) begin
          nxt_st.ale   = 1'b0;
          nxt_st.cnt   = PHASE_LAST;
          nxt_st.state = hpb_pkg::HST_HOLD;
        end
      end
      hpb_pkg::HST_HOLD: begin
        if (expired) begin
          nxt_st.cs_n  = 1'b0;
          nxt_st.oe_n  = st_ff.write;
          nxt_st.d_oe  = st_ff.write;
          nxt_st.d_out = st_ff.wdata;
          nxt_st.cnt   = ACCESS_LAST;
          nxt_st.state = hpb_pkg::HST_ACCESS;
        end
      end
      hpb_pkg::HST_ACCESS: begin
        if (expired) begin
          nxt_st.cs_n     = 1'b1;
          nxt_st.oe_n     = 1'b1;
          nxt_st.rd_valid = ~st_ff.write;
          nxt_st.rd_data  = st_ff.d_s2;
          nxt_st.cnt      = PHASE_LAST;
          nxt_st.state    = hpb_pkg::HST_RECOVER;
        end
      end
      hpb_pkg::HST_RECOVER: begin
        // Write data outlives chip select so the sampled edges agree
        if (expired) begin
          nxt_st.d_oe  = 1'b0;
          nxt_st.we_n  = 1'b1;
          nxt_st.state = hpb_pkg::HST_IDLE;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_ff       <= '0;
      st_ff.state <= hpb_pkg::HST_IDLE;
      st_ff.cs_n  <= hpb_pkg::PIN_IDLE;
      st_ff.oe_n  <= hpb_pkg::PIN_IDLE;
      st_ff.we_n  <= hpb_pkg::PIN_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus.cs_n                      = st_ff.cs_n;
  assign bus.oe_n                      = st_ff.oe_n;
  assign bus.we_n                      = st_ff.we_n;
  assign bus.addr_bit2_or_latch_strobe = st_ff.mux ? st_ff.ale : st_ff.apins[hpb_pkg::ADDR_LSB];
  assign bus.addr_bit3_pin             = st_ff.apins[hpb_pkg::ADDR_LSB+1];
  assign bus.addr_bit4_pin             = st_ff.apins[hpb_pkg::ADDR_LSB+2];
  assign bus.addr_upper                = st_ff.apins[hpb_pkg::ADDR_MSB:hpb_pkg::UPPER_LSB];
  assign bus.bus_mux_select            = mux_mode_i;
  assign bus.size_32                   = size32_i;
  assign bus.host_d_out                = st_ff.d_out;
  assign bus.host_d_oe                 = st_ff.d_oe;
  assign cmd_ready_o                   = st_ff.state == hpb_pkg::HST_IDLE;
  assign rd_valid_o                    = st_ff.rd_valid;
  assign rd_data_o                     = st_ff.rd_data;
  assign irq_o                         = st_ff.irq_s2;

endmodule // hpb_host_end

// [tb/host_parallel_bus_port_assertions.sv]
// Pin-level checks between host end and device end of the parallel port.
// Assumes one clock domain and plain copies of the host_bus_if signals.
`timescale 1ns/10ps
module host_parallel_bus_port_assertions (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // Pins
  input wire logic        cs_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        addr_bit2_or_latch_strobe,
  input wire logic        bus_mux_select,
  input wire logic        size_32,
  input wire logic [31:0] host_d_out,
  input wire logic        host_d_oe,
  input wire logic [31:0] dev_d_out,
  input wire logic        dev_d_oe
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  //////////////////////////////////////////////////////////////////////////////
  // Lag of 5 covers the two-stage pin sampling plus the output register
  property p_oe_release; $rose(oe_n) |-> ##[1:5] !dev_d_oe; endproperty
  a_oe_release: assert property (p_oe_release) else $error("data kept after oe rise");
  property p_cs_end; $rose(cs_n) |-> ##[1:5] !dev_d_oe; endproperty
  a_cs_end: assert property (p_cs_end) else $error("cycle not ended by cs rise");
  property p_no_early_drive; $fell(cs_n) |-> !dev_d_oe [*2]; endproperty
  a_no_early_drive: assert property (p_no_early_drive) else $error("early data drive");
  property p_read_only_drive; dev_d_oe |-> we_n && !host_d_oe; endproperty
  a_read_only_drive: assert property (p_read_only_drive) else $error("drive in write");
  property p_dir_at_select; $fell(cs_n) |-> (oe_n ^ we_n); endproperty
  a_dir_at_select: assert property (p_dir_at_select) else $error("bad direction");
  property p_strobe_first;
    $fell(addr_bit2_or_latch_strobe) && bus_mux_select |-> ##[1:40] $fell(cs_n);
  endproperty
  a_strobe_first: assert property (p_strobe_first) else $error("no select after strobe");
  property p_addr_on_shared;
    addr_bit2_or_latch_strobe && bus_mux_select |-> host_d_oe && cs_n;
  endproperty
  a_addr_on_shared: assert property (p_addr_on_shared) else $error("address not shared");
  property p_strobe_quiet; !cs_n && bus_mux_select |-> !addr_bit2_or_latch_strobe; endproperty
  a_strobe_quiet: assert property (p_strobe_quiet) else $error("strobe in data phase");
  property p_narrow_dev; dev_d_oe && !size_32 |-> dev_d_out[31:16] == 16'h0000; endproperty
  a_narrow_dev: assert property (p_narrow_dev) else $error("device upper half live");
  property p_narrow_host;
    host_d_oe && !size_32 && !cs_n |-> host_d_out[31:16] == 16'h0000;
  endproperty
  a_narrow_host: assert property (p_narrow_host) else $error("host upper half live");

  //////////////////////////////////////////////////////////////////////////////
  c_mux_read: cover property ($fell(cs_n) && bus_mux_select && we_n);
  c_write: cover property ($fell(cs_n) && !we_n);
  c_dev_drive: cover property ($rose(dev_d_oe));
endmodule // host_parallel_bus_port_assertions

// [tb/host_parallel_bus_port_tb_top.sv]
// Bench joining host end and device end through host_bus_if.
// Assumes short host phases (4/8 cycles) and a 250 MHz clock.
`timescale 1ns/10ps
module host_parallel_bus_port_tb_top;
  typedef struct packed {
    logic        mux;
    logic        wide;
    logic [15:2] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } row_t;
  logic        clock_i, rst_i, mux_mode, size32, cmd_valid, cmd_ready, cmd_write;
  logic        rd_valid, rd_req, wr_req, size32_o, mux_o;
  logic [15:2] cmd_addr, acc_addr;
  logic [31:0] cmd_wdata, rd_data, rd_dev, wr_data;
  logic [2:0]  irq;
  logic [7:0]  events, sel0, sel1, sel2, ev_tab [5];
  int          fails, checks_done;
  row_t        rows [4] = '{'{1'h0, 1'h1, 14'h0ABC, 32'h1234_5678, 32'h8765_4321},
                            '{1'h1, 1'h1, 14'h3FFF, 32'hA5A5_5A5A, 32'hC3C3_3C3C},
                            '{1'h0, 1'h0, 14'h0001, 32'hDEAD_BEEF, 32'hFEED_F00D},
                            '{1'h1, 1'h0, 14'h2000, 32'hCAFE_1234, 32'h0BAD_5678}};
  host_bus_if bus ();
  hpb_host_end #(.PHASE_CYC(4), .ACCESS_CYC(8)) i_hpb_host_end (.clock_i(clock_i),
    .rst_i(rst_i), .bus(bus), .mux_mode_i(mux_mode), .size32_i(size32),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .irq_o(irq));
  hpb_device_end i_hpb_device_end (.clock_i(clock_i), .rst_i(rst_i), .bus(bus),
    .acc_addr_o(acc_addr), .rd_req_o(rd_req), .rd_data_i(rd_dev), .wr_req_o(wr_req),
    .wr_data_o(wr_data), .size32_o(size32_o), .mux_mode_o(mux_o), .events_i(events),
    .irq_sel_zero_i(sel0), .irq_sel_one_i(sel1), .irq_sel_two_i(sel2));
  host_parallel_bus_port_assertions i_chk (.clock_i(clock_i), .rst_i(rst_i),
    .cs_n(bus.cs_n), .oe_n(bus.oe_n), .we_n(bus.we_n),
    .addr_bit2_or_latch_strobe(bus.addr_bit2_or_latch_strobe),
    .bus_mux_select(bus.bus_mux_select), .size_32(bus.size_32), .host_d_out(bus.host_d_out),
    .host_d_oe(bus.host_d_oe), .dev_d_out(bus.dev_d_out), .dev_d_oe(bus.dev_d_oe));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] narrow(input logic [31:0] d, input logic w);
    narrow = w ? d : {16'h0000, d[15:0]};
  endfunction
  task automatic give_verdict;
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic m, input logic w);
    @(posedge clock_i) #1;
    rst_i = 1'h1;
    mux_mode = m;
    size32 = w;
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'h0;
  endtask
  // Command held until the edge at which ready is seen high
  task automatic send(input logic w, input logic [15:2] a, input logic [31:0] d);
    @(posedge clock_i) #1;
    cmd_valid = 1'h1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    while (!cmd_ready) @(posedge clock_i) #1;
    @(posedge clock_i) #1;
    cmd_valid = 1'h0;
  endtask
  task automatic wait_pulse(input int sel);
    int   n;
    logic hit;
    n = 0;
    hit = 1'h0;
    while (hit !== 1'h1 && n < 100) begin
      @(negedge clock_i);
      n++;
      hit = sel == 0 ? wr_req : sel == 1 ? rd_req : rd_valid;
    end
    if (hit !== 1'h1) fails++;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'h0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
  initial begin
    {rst_i, mux_mode, size32, cmd_valid, cmd_write} = 5'h1C;
    {cmd_addr, cmd_wdata, rd_dev, events, sel0, sel1, sel2} = '0;
    ev_tab = '{8'h00, 8'h01, 8'h04, 8'h80, 8'hFF};
    foreach (rows[i]) begin
      do_reset(rows[i].mux, rows[i].wide);
      chk({31'h0, bus.cs_n}, 32'h1);
      chk({31'h0, bus.dev_d_oe}, 32'h0);
      rd_dev = rows[i].rdata;
      send(1'h1, rows[i].addr, rows[i].wdata);
      fork
        begin
          wait_pulse(0);
          chk({18'h0, acc_addr}, {18'h0, rows[i].addr});
          chk(wr_data, narrow(rows[i].wdata, rows[i].wide));
        end
        send(1'h0, rows[i].addr + 14'h1, 32'h0);
      join
      wait_pulse(1);
      chk({18'h0, acc_addr}, {18'h0, rows[i].addr + 14'h1});
      wait_pulse(2);
      chk(rd_data, narrow(rows[i].rdata, rows[i].wide));
      chk({30'h0, size32_o, mux_o}, {30'h0, rows[i].wide, rows[i].mux});
    end
    // Strap moved after release must not widen the bus
    @(posedge clock_i) #1 size32 = 1'h1;
    send(1'h1, 14'h0123, 32'hFFFF_FFFF);
    chk({31'h0, cmd_ready}, 32'h0);
    wait_pulse(0);
    chk(wr_data, 32'h0000_FFFF);
    chk({31'h0, size32_o}, 32'h0);
    @(posedge clock_i) #1;
    sel0 = 8'h01;
    sel1 = 8'h06;
    sel2 = 8'h80;
    foreach (ev_tab[i]) begin
      @(posedge clock_i) #1 events = ev_tab[i];
      repeat (5) @(posedge clock_i) #1;
      chk({29'h0, irq}, {29'h0, |(events & sel2), |(events & sel1), |(events & sel0)});
      chk({29'h0, bus.host_irq_two, bus.host_irq_one, bus.host_irq_zero},
          {29'h0, |(events & sel2), |(events & sel1), |(events & sel0)});
    end
    give_verdict();
  end
endmodule // host_parallel_bus_port_tb_top
